/* File: hdl/cps_coherency_port.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_coherency_port (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic slave_bus_clock_enable_i,
   // Write address
   input wire logic awvalid_i,
   input wire cps_pkg::cps_addr_t aw_i,
   output logic awready_o,
   // Write data
   input wire logic wvalid_i,
   input wire cps_pkg::cps_wdata_t w_i,
   output logic wready_o,
   // Write response
   output logic bvalid_o,
   output cps_pkg::cps_bresp_t b_o,
   input wire logic bready_i,
   // Read address
   input wire logic arvalid_i,
   input wire cps_pkg::cps_addr_t ar_i,
   output logic arready_o,
   // Read data
   output logic rvalid_o,
   output cps_pkg::cps_rdata_t r_o,
   input wire logic rready_i,
   // Decoded attributes of the last accepted request
   output cps_pkg::cps_attr_t wr_attr_o,
   output cps_pkg::cps_attr_t rd_attr_o,
   output logic [1:0] rd_burst_o
);
   typedef enum logic [1:0] {
      CPS_W_ADDR = 2'h0,
      CPS_W_DATA = 2'h1,
      CPS_W_RESP = 2'h3
   } cps_wstate_t;
   typedef enum logic [1:0] {
      CPS_R_ADDR = 2'h0,
      CPS_R_DATA = 2'h1
   } cps_rstate_t;

   localparam int WORDS = 16;

   // Small backing store so the port answers reads with written data
   logic [cps_pkg::DATA_W-1:0] mem_reg [WORDS];

   cps_wstate_t ws_reg, ws_next;
   cps_rstate_t rs_reg, rs_next;
   cps_pkg::cps_addr_t awq_reg, awq_next, arq_reg, arq_next;
   logic [3:0] wbeat_reg, wbeat_next, rbeat_reg, rbeat_next;
   logic werr_reg, werr_next;
   logic bvalid_next, rvalid_next;
   logic awready_next, wready_next, arready_next;
   cps_pkg::cps_bresp_t b_next;
   cps_pkg::cps_rdata_t r_next;
   cps_pkg::cps_attr_t wa_next, ra_next;
   logic [1:0] rb_next;
   logic aw_hs, w_hs, ar_hs;

   function automatic cps_pkg::cps_attr_t decode(input logic [cps_pkg::USER_W-1:0] u,
                                                 input logic [3:0] cache);
      cps_pkg::cps_attr_t a;
      a.attr = u[cps_pkg::ATTR_MSB:cps_pkg::ATTR_LSB];
      a.shared = u[cps_pkg::SHARE_BIT];
      a.cacheable = cache[1];
      // Undefined codes are flagged, not interpreted
      unique case (a.attr)
         cps_pkg::ATTR_SO, cps_pkg::ATTR_DEV, cps_pkg::ATTR_NC,
         cps_pkg::ATTR_WT, cps_pkg::ATTR_WB_NA, cps_pkg::ATTR_WB_WA: a.known = 1'b1;
         default: a.known = 1'b0;
      endcase
      return a;
   endfunction : decode

   function automatic logic [3:0] word_idx(input cps_pkg::cps_addr_t a, input logic [3:0] beat);
      logic [3:0] base;
      base = a.addr[6:3];
      if (a.burst == cps_pkg::BURST_FIXED) begin
         return base;
      end
      // Wraps inside the 16-word store on purpose
      return 4'(base + beat);
   endfunction : word_idx

   // Handshakes only count on enabled edges
   assign aw_hs = slave_bus_clock_enable_i && awvalid_i && awready_o;
   assign w_hs = slave_bus_clock_enable_i && wvalid_i && wready_o;
   assign ar_hs = slave_bus_clock_enable_i && arvalid_i && arready_o;

   always_comb begin
      ws_next = ws_reg;
      awq_next = awq_reg;
      wbeat_next = wbeat_reg;
      werr_next = werr_reg;
      bvalid_next = bvalid_o;
      b_next = b_o;
      wa_next = wr_attr_o;
      if (slave_bus_clock_enable_i) begin
         unique case (ws_reg)
            CPS_W_ADDR: begin
               if (aw_hs) begin
                  awq_next = aw_i;
                  wa_next = decode(aw_i.user, aw_i.cache);
                  wbeat_next = '0;
                  werr_next = aw_i.lock[1];
                  ws_next = CPS_W_DATA;
               end
            end
            CPS_W_DATA: begin
               if (w_hs) begin
                  wbeat_next = wbeat_reg + 4'h1;
                  // Last flag must agree with the beat count from the length field
                  if (w_i.last != (wbeat_reg == awq_reg.len) || w_i.id != awq_reg.id) begin
                     werr_next = 1'b1;
                  end
                  if (wbeat_reg == awq_reg.len) begin
                     bvalid_next = 1'b1;
                     b_next.id = awq_reg.id;
                     b_next.resp = (werr_next || !wa_next.known) ? cps_pkg::RESP_SLVERR :
                                   cps_pkg::RESP_OKAY;
                     ws_next = CPS_W_RESP;
                  end
               end
            end
            CPS_W_RESP: begin
               if (bready_i) begin
                  bvalid_next = 1'b0;
                  ws_next = CPS_W_ADDR;
               end
            end
            default: ws_next = CPS_W_ADDR;
         endcase
      end
      awready_next = (ws_next == CPS_W_ADDR);
      wready_next = (ws_next == CPS_W_DATA);
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ws_reg <= CPS_W_ADDR;
         awq_reg <= '0;
         wbeat_reg <= '0;
         werr_reg <= 1'b0;
         bvalid_o <= 1'b0;
         b_o <= '0;
         wr_attr_o <= '0;
         awready_o <= 1'b0;
         wready_o <= 1'b0;
      end else begin
         ws_reg <= ws_next;
         awq_reg <= awq_next;
         wbeat_reg <= wbeat_next;
         werr_reg <= werr_next;
         bvalid_o <= bvalid_next;
         b_o <= b_next;
         wr_attr_o <= wa_next;
         awready_o <= awready_next;
         wready_o <= wready_next;
      end
   end

   // Strobed byte lanes only; memory has no reset, it is plain storage
   always_ff @(posedge clk_i) begin
      if (w_hs) begin
         for (int i = 0; i < cps_pkg::STRB_W; i++) begin
            if (w_i.strb[i]) begin
               mem_reg[word_idx(awq_reg, wbeat_reg)][i*8 +: 8] <= w_i.data[i*8 +: 8];
            end
         end
      end
   end

   always_comb begin
      rs_next = rs_reg;
      arq_next = arq_reg;
      rbeat_next = rbeat_reg;
      rvalid_next = rvalid_o;
      r_next = r_o;
      ra_next = rd_attr_o;
      rb_next = rd_burst_o;
      if (slave_bus_clock_enable_i) begin
         unique case (rs_reg)
            CPS_R_ADDR: begin
               if (ar_hs) begin
                  arq_next = ar_i;
                  ra_next = decode(ar_i.user, ar_i.cache);
                  rb_next = ar_i.burst;
                  rbeat_next = '0;
                  rvalid_next = 1'b1;
                  r_next.data = mem_reg[word_idx(ar_i, 4'h0)];
                  r_next.id = ar_i.id;
                  r_next.resp = ra_next.known ? cps_pkg::RESP_OKAY : cps_pkg::RESP_SLVERR;
                  r_next.last = (ar_i.len == 4'h0);
                  rs_next = CPS_R_DATA;
               end
            end
            CPS_R_DATA: begin
               if (rready_i) begin
                  if (r_o.last) begin
                     rvalid_next = 1'b0;
                     rs_next = CPS_R_ADDR;
                  end else begin
                     rbeat_next = rbeat_reg + 4'h1;
                     r_next.data = mem_reg[word_idx(arq_reg, rbeat_next)];
                     r_next.last = (rbeat_next == arq_reg.len);
                  end
               end
            end
            default: rs_next = CPS_R_ADDR;
         endcase
      end
      arready_next = (rs_next == CPS_R_ADDR);
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rs_reg <= CPS_R_ADDR;
         arq_reg <= '0;
         rbeat_reg <= '0;
         rvalid_o <= 1'b0;
         r_o <= '0;
         rd_attr_o <= '0;
         rd_burst_o <= cps_pkg::BURST_INCR;
         arready_o <= 1'b0;
      end else begin
         rs_reg <= rs_next;
         arq_reg <= arq_next;
         rbeat_reg <= rbeat_next;
         rvalid_o <= rvalid_next;
         r_o <= r_next;
         rd_attr_o <= ra_next;
         rd_burst_o <= rb_next;
         arready_o <= arready_next;
      end
   end

   sequence wr_last_beat_s;
      w_hs && (wbeat_reg == awq_reg.len);
   endsequence
   sequence bresp_up_s;
      bvalid_o && (b_o.id == $past(awq_reg.id));
   endsequence

   burst_ends_resp_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_last_beat_s |=> bresp_up_s) else $error("write burst end gave no response");
   gated_edges_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !slave_bus_clock_enable_i |=> $stable(ws_reg) && $stable(rs_reg))
      else $error("state moved without bus clock enable");
   rd_len_beats_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rvalid_o && rready_i && slave_bus_clock_enable_i && !r_o.last |=> rbeat_reg != 4'h0)
      else $error("read beat count did not advance");
   fixed_forward_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ar_hs |=> rd_burst_o == $past(ar_i.burst)) else $error("read burst type not forwarded");
   wr_attr_decode_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      aw_hs |=> wr_attr_o.attr == $past(aw_i.user[4:1]) &&
                wr_attr_o.shared == $past(aw_i.user[0]))
      else $error("write sideband not decoded");
   rd_attr_decode_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ar_hs && ar_i.user[4:2] == 3'h2 |=> !rd_attr_o.known && r_o.resp == cps_pkg::RESP_SLVERR)
      else $error("undefined read attribute accepted");
   cache_kept_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      aw_hs |=> awq_reg.cache == $past(aw_i.cache)) else $error("write cache type lost");
   ready_excl_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !(awready_o && wready_o)) else $error("address and data ready together");
endmodule : cps_coherency_port
`default_nettype wire

/* File: hdl/cps_pkg.sv */
// Notes on behaviour
// - Both address channels carry five sideband bits; only defined codes are interpreted.
// - Every address handshake carries a four-bit burst length in beats minus one.
// - Every request carries a four-bit cache type, accepted on both address channels.
// - Write data is 64-bit beats with eight strobes marking valid byte lanes.
// - A slave bus clock enable qualifies every edge the port samples or drives, except the first edge after reset, which raises awready_o and arready_o.
// - Reads accept fixed bursts and forward that burst type unchanged.
package cps_pkg;
   localparam int ADDR_W = 32;
   localparam int ID_W = 3;
   localparam int DATA_W = 64;
   localparam int STRB_W = 8;
   localparam int LEN_W = 4;
   localparam int USER_W = 5;
   localparam int ATTR_MSB = 4;
   localparam int ATTR_LSB = 1;
   localparam int SHARE_BIT = 0;
   localparam logic [3:0] ATTR_SO = 4'h0;
   localparam logic [3:0] ATTR_DEV = 4'h1;
   localparam logic [3:0] ATTR_NC = 4'h3;
   localparam logic [3:0] ATTR_WT = 4'h6;
   localparam logic [3:0] ATTR_WB_NA = 4'h7;
   localparam logic [3:0] ATTR_WB_WA = 4'hf;
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [1:0] BURST_WRAP = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_EXOKAY = 2'h1;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [1:0] burst;
      logic [3:0] cache;
      logic [ID_W-1:0] id;
      logic [LEN_W-1:0] len;
      logic [1:0] lock;
      logic [2:0] prot;
      logic [1:0] size;
      logic [USER_W-1:0] user;
   } cps_addr_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [ID_W-1:0] id;
      logic last;
      logic [STRB_W-1:0] strb;
   } cps_wdata_t;

   typedef struct packed {
      logic [ID_W-1:0] id;
      logic [1:0] resp;
   } cps_bresp_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [ID_W-1:0] id;
      logic [1:0] resp;
      logic last;
   } cps_rdata_t;

   typedef struct packed {
      logic [3:0] attr;
      logic shared;
      logic cacheable;
      logic known;
   } cps_attr_t;
endpackage : cps_pkg

/* File: testbench/cps_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_master_model (
   // Clock and enable
   input wire logic clk_i,
   input wire logic en_i,
   // Write channels
   output logic awvalid_o,
   output cps_pkg::cps_addr_t aw_o,
   input wire logic awready_i,
   output logic wvalid_o,
   output cps_pkg::cps_wdata_t w_o,
   input wire logic wready_i,
   input wire logic bvalid_i,
   input wire cps_pkg::cps_bresp_t b_i,
   output logic bready_o,
   // Read channels
   output logic arvalid_o,
   output cps_pkg::cps_addr_t ar_o,
   input wire logic arready_i,
   input wire logic rvalid_i,
   input wire cps_pkg::cps_rdata_t r_i,
   output logic rready_o
);
   cps_pkg::cps_bresp_t b_q;
   cps_pkg::cps_rdata_t r_q;
   initial begin
      {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
      aw_o = '0;
      w_o = '0;
      ar_o = '0;
   end
   // Decided before the edge, so the taking edge is never raced
   task automatic take(input int c);
      logic ok;
      do begin
         @(negedge clk_i);
         ok = en_i && (c == 0 ? awready_i : c == 1 ? wready_i : c == 2 ? bvalid_i :
                       c == 3 ? arready_i : rvalid_i);
         b_q = b_i;
         r_q = r_i;
         @(posedge clk_i);
      end while (!ok);
      #1;
   endtask : take
   task automatic stall();
      repeat ($urandom_range(2, 1)) begin
         @(posedge clk_i);
         #1;
      end
   endtask : stall
   task automatic write(input cps_pkg::cps_addr_t a, input logic [63:0] d [16],
                        input logic [7:0] s [16], input bit bad,
                        output cps_pkg::cps_bresp_t b);
      awvalid_o = 1'b1;
      aw_o = a;
      take(0);
      awvalid_o = 1'b0;
      aw_o = ~a;
      wvalid_o = 1'b1;
      for (int i = 0; i <= a.len; i++) begin
         w_o = '{data: d[i], id: bad ? ~a.id : a.id, last: i == a.len, strb: s[i]};
         take(1);
      end
      wvalid_o = 1'b0;
      w_o = ~w_o;
      stall();
      bready_o = 1'b1;
      take(2);
      b = b_q;
      bready_o = 1'b0;
   endtask : write
   task automatic read(input cps_pkg::cps_addr_t a, output cps_pkg::cps_rdata_t r [16]);
      arvalid_o = 1'b1;
      ar_o = a;
      take(3);
      arvalid_o = 1'b0;
      ar_o = ~a;
      rready_o = 1'b1;
      for (int i = 0; i <= a.len; i++) begin
         take(4);
         r[i] = r_q;
         if ($urandom_range(1) && i < a.len) begin
            rready_o = 1'b0;
            stall();
            rready_o = 1'b1;
         end
      end
      rready_o = 1'b0;
   endtask : read
endmodule : cps_master_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("Error %s expected %h seen %h", n, (e), (g)); end end
module testbench;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic en = 1'b0;
   int err_count = 0;
   int n_tests = 0;
   logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   cps_pkg::cps_addr_t aw, ar;
   cps_pkg::cps_wdata_t w;
   cps_pkg::cps_bresp_t b;
   cps_pkg::cps_rdata_t r;
   cps_pkg::cps_attr_t wat, rat;
   logic [1:0] rbu;
   logic [63:0] mem [16];
   logic [63:0] kn [16];
   logic [3:0] codes [6] = '{cps_pkg::ATTR_SO, cps_pkg::ATTR_DEV, cps_pkg::ATTR_NC,
                             cps_pkg::ATTR_WT, cps_pkg::ATTR_WB_NA, cps_pkg::ATTR_WB_WA};
   always #12.5 clk_i = ~clk_i;
   // Clock controller lets roughly three edges in four through
   always @(posedge clk_i) en <= #1 ($urandom_range(3) != 0);
   cps_coherency_port cps_coherency_port_i (
      .clk_i(clk_i), .resetn_i(resetn_i), .slave_bus_clock_enable_i(en),
      .awvalid_i(awv), .aw_i(aw), .awready_o(awr), .wvalid_i(wv), .w_i(w), .wready_o(wr),
      .bvalid_o(bv), .b_o(b), .bready_i(br), .arvalid_i(arv), .ar_i(ar), .arready_o(arr),
      .rvalid_o(rv), .r_o(r), .rready_i(rr), .wr_attr_o(wat), .rd_attr_o(rat),
      .rd_burst_o(rbu));
   cps_master_model cps_master_model_i (
      .clk_i(clk_i), .en_i(en), .awvalid_o(awv), .aw_o(aw), .awready_i(awr),
      .wvalid_o(wv), .w_o(w), .wready_i(wr), .bvalid_i(bv), .b_i(b), .bready_o(br),
      .arvalid_o(arv), .ar_o(ar), .arready_i(arr), .rvalid_i(rv), .r_i(r), .rready_o(rr));
   function automatic bit defd(logic [3:0] c);
      return c inside {codes};
   endfunction : defd
   function automatic cps_pkg::cps_attr_t att(cps_pkg::cps_addr_t a);
      return '{attr: a.user[4:1], shared: a.user[0], cacheable: a.cache[1],
               known: defd(a.user[4:1])};
   endfunction : att
   // Mostly legal requests; an undefined code or upper lock bit now and then
   function automatic cps_pkg::cps_addr_t req();
      cps_pkg::cps_addr_t a;
      a.addr = $urandom;
      a.burst = 2'($urandom_range(2));
      a.cache = 4'($urandom);
      a.id = 3'($urandom);
      a.len = 4'($urandom_range(7));
      a.lock = {$urandom_range(7) == 0, 1'b0};
      a.prot = 3'($urandom);
      a.size = 2'h3;
      // Codes 4 and 5 are undefined and must be answered with an error
      a.user = {$urandom_range(7) == 0 ? 4'h4 + 4'($urandom_range(1)) :
                codes[$urandom_range(5)], 1'($urandom)};
      return a;
   endfunction : req
   task automatic close_out();
      $display("Checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   initial begin
      #(25 * 40000);
      $display("Error watchdog expected done seen hang");
      err_count++;
      close_out();
   end
   initial begin
      cps_pkg::cps_addr_t a;
      cps_pkg::cps_bresp_t bq;
      cps_pkg::cps_rdata_t rq [16];
      logic [63:0] d [16];
      logic [7:0] s [16];
      logic [31:0] wa;
      bit bad;
      bit e;
      int x;
      void'($urandom(32'hbfec4a41));
      foreach (kn[i]) kn[i] = '0;
      repeat (16) @(posedge clk_i);
      #1 resetn_i = 1'b1;
      `CHK("rd_burst_rst", cps_pkg::BURST_INCR, rbu)
      for (int k = 0; k < 60; k++) begin
         a = req();
         wa = a.addr;
         bad = $urandom_range(7) == 0;
         foreach (d[i]) begin
            d[i] = {$urandom, $urandom};
            s[i] = 8'($urandom);
         end
         cps_master_model_i.write(a, d, s, bad, bq);
         e = !defd(a.user[4:1]) || a.lock[1] || bad;
         `CHK("bresp", e ? cps_pkg::RESP_SLVERR : cps_pkg::RESP_OKAY, bq.resp)
         `CHK("bid", a.id, bq.id)
         `CHK("wr_attr", att(a), wat)
         for (int i = 0; i <= a.len; i++) begin
            x = (a.addr[6:3] + (a.burst == cps_pkg::BURST_FIXED ? 0 : i)) % 16;
            // Strobed lanes land even when the response is an error
            for (int j = 0; j < 8; j++) begin
               if (s[i][j]) begin
                  mem[x][8*j+:8] = d[i][8*j+:8];
                  kn[x][8*j+:8] = 8'hff;
               end
            end
         end
         a = req();
         a.addr = wa;
         cps_master_model_i.read(a, rq);
         // Reads ignore the lock field; only an undefined code is refused
         e = !defd(a.user[4:1]);
         `CHK("rd_burst", a.burst, rbu)
         `CHK("rd_attr", att(a), rat)
         for (int i = 0; i <= a.len; i++) begin
            x = (a.addr[6:3] + (a.burst == cps_pkg::BURST_FIXED ? 0 : i)) % 16;
            `CHK("rresp", e ? cps_pkg::RESP_SLVERR : cps_pkg::RESP_OKAY, rq[i].resp)
            `CHK("rid", a.id, rq[i].id)
            `CHK("rlast", i == a.len, rq[i].last)
            `CHK("rdata", mem[x] & kn[x], rq[i].data & kn[x])
         end
      end
      close_out();
   end
endmodule : testbench
`default_nettype wire
